//--- shared/mwb_pkg.sv
/*
  Constants for the memory window base register and subsystem identity
  registers of the configuration header.
  Assumes a configuration port with dword offsets and byte enables.
*/
// How it works
// - Host sets a 27-bit memory window base in register bits 31..5.
// - When decode enabled, address bits 31..5 matching base claim memory commands.
// - Base is host read/write, cleared by hardware reset only.
// - Bits 2..1 memory type read zero, writes ignored.
// - Bit 0 space indicator reads zero, writes ignored.
// - Bit 4 size bit reads zero so all-ones readback shows 32 bytes.
// - Read-only 16-bit subsystem vendor identifier at configuration offset 2Ch.
// - Subsystem vendor identifier mirrors bus configuration register 23 bits 15..0.
// - Subsystem identity defaults to zero, meaning identification unsupported.
// - 16-bit subsystem identifier at offset 2Eh identifies the card.
`default_nettype none
package mwb_pkg;
  localparam logic [7:0] MWB_OFF_BAR = 8'h14;
  localparam logic [7:0] MWB_OFF_SSID = 8'h2C;
  localparam logic [7:0] MWB_OFF_SSVID = 8'h2C;
  localparam logic [7:0] MWB_OFF_SID = 8'h2E;
  localparam int MWB_BASE_LSB = 5;
  localparam int MWB_BASE_W = 27;
  localparam logic [4:0] MWB_LOW_BITS = 5'h00;
  localparam logic [15:0] MWB_ID_RESET = 16'h0000;
  localparam logic [26:0] MWB_BASE_RESET = 27'h0000000;
  localparam logic [3:0] MWB_CMD_MEM_READ = 4'h6;
  localparam logic [3:0] MWB_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] MWB_CMD_MEM_RDMULT = 4'hC;
  localparam logic [3:0] MWB_CMD_MEM_RDLINE = 4'hE;
  localparam logic [3:0] MWB_CMD_MEM_WRINV = 4'hF;
endpackage : mwb_pkg
`default_nettype wire

//--- rtl/mwb_decode.sv
/*
  Address phase comparator for the memory window.
  Assumes address phase inputs already synchronised to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module mwb_decode
  import mwb_pkg::*;
(
  // Compare inputs
  input wire logic [31:0] addr_i,
  input wire logic [3:0] cmd_i,
  input wire logic [MWB_BASE_W-1:0] base_i,
  input wire logic enable_i,
  // Result
  output logic hit_o
);
  // Memory command decode; only these five codes may claim
  function automatic logic is_mem_cmd(input logic [3:0] c);
    is_mem_cmd = (c == MWB_CMD_MEM_READ) || (c == MWB_CMD_MEM_WRITE) ||
                 (c == MWB_CMD_MEM_RDMULT) || (c == MWB_CMD_MEM_RDLINE) ||
                 (c == MWB_CMD_MEM_WRINV);
  endfunction : is_mem_cmd

  // Upper 27 address bits against the base
  assign hit_o = enable_i && is_mem_cmd(cmd_i) &&
                 (addr_i[31:MWB_BASE_LSB] == base_i);
endmodule : mwb_decode
`default_nettype wire

//--- rtl/mwb_regs.sv
/*
  Memory window base register, subsystem vendor identifier and subsystem
  identifier of the configuration header, plus memory address decode.
  Assumes a configuration port (dword offset, byte enables, read/write
  strobes) on mclk_i, and PCI address phase signals arriving from pins.
*/
`timescale 1ns/1ps
`default_nettype none
module mwb_regs
  import mwb_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Configuration access port
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_off_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // Command register memory decode enable
  input wire logic memory_decode_enable_i,
  // Bus configuration register 23 and 24 aliases
  input wire logic [15:0] bus_config_reg_23_i,
  input wire logic [15:0] bus_config_reg_24_i,
  // PCI address phase from pins
  input wire logic frame_start_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  output logic devsel_o
);
  typedef struct packed {
    logic [1:0] frm_s;
    logic [31:0] ad_s1;
    logic [31:0] ad_s2;
    logic [3:0] cbe_s1;
    logic [3:0] cbe_s2;
    logic frame_q;
    logic [MWB_BASE_W-1:0] mem_window_base;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [31:0] rdata;
    logic ack;
    logic devsel;
  } mwb_state_s;

  mwb_state_s st;
  mwb_state_s next_st;
  logic hit;
  logic [31:0] bar_word;

  // Readback of base register; low five bits fixed at zero
  assign bar_word = {st.mem_window_base, MWB_LOW_BITS};

  mwb_decode u_decode (
    .addr_i(st.ad_s2),
    .cmd_i(st.cbe_s2),
    .base_i(st.mem_window_base),
    .enable_i(memory_decode_enable_i),
    .hit_o(hit)
  );

  // Byte-lane merge into the 27-bit base field
  function automatic logic [MWB_BASE_W-1:0] write_byte(
    input logic [MWB_BASE_W-1:0] cur, input logic [31:0] wd, input integer ln);
    logic [31:0] w;
    w = {cur, MWB_LOW_BITS};
    w[ln*8 +: 8] = wd[ln*8 +: 8];
    write_byte = w[31:MWB_BASE_LSB];
  endfunction : write_byte

  // Next state: pin sync, register access, decode
  always_comb
  begin
    next_st = st;
    next_st.frm_s = {st.frm_s[0], frame_start_i};
    next_st.ad_s1 = ad_i;
    next_st.ad_s2 = st.ad_s1;
    next_st.cbe_s1 = cbe_i;
    next_st.cbe_s2 = st.cbe_s1;
    // Qualified hit from the second sync stage, where frame, address and
    // command of one phase line up; one stage later the address lines
    // already show the released value
    next_st.frame_q = st.frm_s[1] && hit;
    // Identity aliases track the EEPROM-loaded registers
    next_st.ssvid = bus_config_reg_23_i[15:0];
    next_st.ssid = bus_config_reg_24_i;
    next_st.ack = cfg_wr_i || cfg_rd_i;
    next_st.rdata = 32'h00000000;
    if (cfg_rd_i)
    begin
      if (cfg_off_i == MWB_OFF_BAR)
        next_st.rdata = bar_word;
      else if (cfg_off_i == MWB_OFF_SSVID)
        next_st.rdata = {st.ssid, st.ssvid};
    end
    // Only the base bytes are writable; identity writes are dropped
    if (cfg_wr_i && cfg_off_i == MWB_OFF_BAR)
    begin
      for (int ln = 0; ln < 4; ln++)
        if (cfg_be_i[ln])
          next_st.mem_window_base =
            write_byte(next_st.mem_window_base, cfg_wdata_i, ln);
    end
    // Claim one cycle after the qualified hit
    next_st.devsel = st.frame_q;
  end

  // Hardware reset clears base; identities default to zero
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st <= '0;
      st.mem_window_base <= MWB_BASE_RESET;
      st.ssvid <= MWB_ID_RESET;
      st.ssid <= MWB_ID_RESET;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign cfg_rdata_o = st.rdata;
  assign cfg_ack_o = st.ack;
  assign devsel_o = st.devsel;

  // Low bits of the readback never carry written ones
  property p_low_zero;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && cfg_rd_i && cfg_off_i == MWB_OFF_BAR) |=>
        cfg_rdata_o[4:0] == MWB_LOW_BITS;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("base low bits not zero");

  // Full byte-enable base write is held in the register on the next cycle
  property p_base_wr;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && cfg_wr_i && cfg_off_i == MWB_OFF_BAR && cfg_be_i == 4'hF)
        |=> st.mem_window_base == $past(cfg_wdata_i[31:MWB_BASE_LSB]);
  endproperty
  a_base_wr: assert property (p_base_wr)
    else $error("base write lost");

  // No qualified hit forms while decode is off; the claim follows it
  property p_no_claim_disabled;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && !memory_decode_enable_i) |=> !st.frame_q;
  endproperty
  a_no_claim_disabled: assert property (p_no_claim_disabled)
    else $error("claim while decode disabled");

  // Identity writes leave values alone
  property p_id_ro;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && cfg_wr_i && cfg_off_i == MWB_OFF_SSVID &&
       $stable(bus_config_reg_23_i)) |=> $stable(st.ssvid);
  endproperty
  a_id_ro: assert property (p_id_ro)
    else $error("identity changed by write");

  // Every access with enable high acknowledged next cycle
  property p_ack;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && (cfg_wr_i || cfg_rd_i)) |=> cfg_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access not acknowledged");

  // Vendor identifier takes its alias at each enabled edge
  property p_mirror;
    @(posedge mclk_i) disable iff (reset_i)
      ce_i |=>
        st.ssvid == $past(bus_config_reg_23_i);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("vendor id alias mismatch");

  // Vendor and subsystem identifiers sit at 2Ch / 2Eh halves
  property p_id_read;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && cfg_rd_i && cfg_off_i == MWB_OFF_SSVID) |=>
        cfg_rdata_o == {$past(st.ssid), $past(st.ssvid)};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity read wrong");

  // Base cleared right after reset
  property p_reset_clear;
    @(posedge mclk_i) $fell(reset_i) |-> st.mem_window_base == MWB_BASE_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("base not cleared by reset");

  // Low enable freezes every stored bit, base included
  property p_freeze;
    @(posedge mclk_i) disable iff (reset_i)
      !ce_i |=>
        $stable(st);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  // No acknowledge without an access behind it
  property p_no_spurious_ack;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && !cfg_wr_i && !cfg_rd_i) |=>
        !cfg_ack_o;
  endproperty
  a_no_spurious_ack: assert property (p_no_spurious_ack)
    else $error("acknowledge without access");

  // A write completes with an empty data word
  property p_wr_rdata_zero;
    @(posedge mclk_i) disable iff (reset_i)
      (ce_i && cfg_wr_i && !cfg_rd_i) |=>
        cfg_rdata_o == 32'h00000000;
  endproperty
  a_wr_rdata_zero: assert property (p_wr_rdata_zero)
    else $error("write returned data");
endmodule : mwb_regs
`default_nettype wire

//--- dv/mwb_host_model.sv
/*
  Host bridge model that drives PCI address phases into the block.
  Assumes the bench calls addr_phase from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module mwb_host_model (
  // Clock
  input wire logic mclk_i,
  // Address phase pins
  output logic frame_o,
  output logic [31:0] ad_o,
  output logic [3:0] cbe_o
);
  // Idle pins
  initial
  begin
    frame_o = 1'b0;
    ad_o = 32'h00000000;
    cbe_o = 4'h0;
  end
  // One-cycle phase; released lines show inverted data, no pull-up here
  task automatic addr_phase(input logic [31:0] a, input logic [3:0] c);
    @(negedge mclk_i);
    frame_o = 1'b1;
    ad_o = a;
    cbe_o = c;
    @(negedge mclk_i);
    frame_o = 1'b0;
    ad_o = ~a;
    cbe_o = ~c;
  endtask : addr_phase
endmodule : mwb_host_model
`default_nettype wire

//--- dv/tb_mwb_regs.sv
/*
  Self-checking bench for the memory window and identity registers.
  Assumes config acks arrive within a few cycles of each request.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  total_checks++; \
  if ((a) !== (b)) \
  begin \
    n_fail++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); \
  end
module tb_mwb_regs
  import mwb_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i, ce_i, cfg_wr_i, cfg_rd_i, cfg_ack_o, devsel_o;
  logic memory_decode_enable_i, frame;
  logic [7:0] cfg_off_i;
  logic [3:0] cfg_be_i, cbe;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, ad, base;
  logic [15:0] r23, r24;
  logic [32:0] rq[$];
  logic [32:0] e;
  bit dq[$];
  logic [3:0] cmds[5];
  int n_fail, total_checks;
  always #2 mclk_i = ~mclk_i;
  mwb_regs u_mwb_regs (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_off_i(cfg_off_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
    .memory_decode_enable_i(memory_decode_enable_i),
    .bus_config_reg_23_i(r23), .bus_config_reg_24_i(r24),
    .frame_start_i(frame), .ad_i(ad), .cbe_i(cbe), .devsel_o(devsel_o));
  mwb_host_model u_mwb_host_model (.mclk_i(mclk_i), .frame_o(frame),
    .ad_o(ad), .cbe_o(cbe));
  task automatic complete_run();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // One access; read notes its expected data, bounded wait for the ack
  task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d);
    int i;
    @(negedge mclk_i);
    cfg_wr_i = w;
    cfg_rd_i = !w;
    cfg_off_i = o;
    cfg_wdata_i = d;
    rq.push_back({!w, d});
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
    for (i = 0; i < 4 && rq.size() != 0; i++) @(negedge mclk_i);
    if (rq.size() != 0)
    begin
      n_fail++;
      complete_run();
    end
  endtask : acc
  // Address phase; the claim lands four edges later, so six is ample
  task automatic hit(input logic [31:0] a, input logic [3:0] c, input bit x);
    if (x)
      dq.push_back(1'b1);
    u_mwb_host_model.addr_phase(a, c);
    repeat (6) @(negedge mclk_i);
  endtask : hit
  // Watcher: settled outputs taken at the falling edge
  always @(negedge mclk_i)
  begin
    if (cfg_ack_o === 1'b1)
    begin
      `CHK(rq.size() != 0, 1'b1)
      e = (rq.size() != 0) ? rq.pop_front() : 33'h100000000;
      if (e[32])
      begin
        `CHK(cfg_rdata_o, e[31:0])
      end
    end
    if (devsel_o === 1'b1)
    begin
      `CHK(dq.size() != 0, 1'b1)
      if (dq.size() != 0)
        void'(dq.pop_front());
    end
  end
  initial
  begin
    {reset_i, ce_i, cfg_be_i} = 6'h3F;
    {cfg_wr_i, cfg_rd_i, memory_decode_enable_i} = 3'h0;
    {cfg_off_i, cfg_wdata_i, r23, r24} = 72'h0;
    cmds = '{MWB_CMD_MEM_READ, MWB_CMD_MEM_WRITE, MWB_CMD_MEM_RDMULT,
      MWB_CMD_MEM_RDLINE, MWB_CMD_MEM_WRINV};
    void'($urandom(765));
    repeat (16) @(negedge mclk_i);
    reset_i = 1'b0;
    acc(1'b0, MWB_OFF_BAR, 32'h00000000);
    acc(1'b0, MWB_OFF_SSVID, 32'h00000000);
    $display("test reset values done");
    r23 = 16'($urandom);
    r24 = 16'($urandom);
    acc(1'b0, MWB_OFF_SSVID, {r24, r23});
    acc(1'b1, MWB_OFF_SSVID, 32'hFFFFFFFF);
    acc(1'b0, MWB_OFF_SSVID, {r24, r23});
    acc(1'b0, 8'h30, 32'h00000000);
    $display("test identity done");
    acc(1'b1, MWB_OFF_BAR, 32'hFFFFFFFF);
    acc(1'b0, MWB_OFF_BAR, 32'hFFFFFFE0);
    base = $urandom | 32'h80000000;
    base[4:0] = 5'h00;
    acc(1'b1, MWB_OFF_BAR, base | 32'h0000001F);
    acc(1'b0, MWB_OFF_BAR, base);
    $display("test base register done");
    // Enable low: a presented write must neither land nor be acknowledged
    @(negedge mclk_i);
    ce_i = 1'b0;
    cfg_wr_i = 1'b1;
    cfg_off_i = MWB_OFF_BAR;
    cfg_wdata_i = 32'h00000000;
    repeat (3) @(negedge mclk_i);
    cfg_wr_i = 1'b0;
    ce_i = 1'b1;
    acc(1'b0, MWB_OFF_BAR, base);
    $display("test clock enable done");
    // Base is loaded first, only then decode switched on
    hit(base, MWB_CMD_MEM_READ, 1'b0);
    memory_decode_enable_i = 1'b1;
    foreach (cmds[k])
      hit(base | 32'h0000001F, cmds[k], 1'b1);
    hit(base, 4'h2, 1'b0);
    hit(base ^ 32'h00000020, MWB_CMD_MEM_READ, 1'b0);
    $display("test decode done");
    reset_i = 1'b1;
    // Hardware reset clears the command register too, so decode goes off
    memory_decode_enable_i = 1'b0;
    @(negedge mclk_i);
    reset_i = 1'b0;
    acc(1'b0, MWB_OFF_BAR, 32'h00000000);
    hit(base, MWB_CMD_MEM_READ, 1'b0);
    `CHK(dq.size(), 0)
    $display("test second reset done");
    complete_run();
  end
endmodule : tb_mwb_regs
`default_nettype wire
